// File: hdl/wdt_pkg.sv
// Constants, register layout and helpers of the watchdog block.
// Assumes a 100 MHz system clock and a 32-bit register bus.
package wdt_pkg;

	// Register byte offsets
	localparam logic [7:0] CTRL_OFS  = 8'h60;
	localparam logic [7:0] CAUSE_OFS = 8'h64;

	// Control register fields
	localparam int CTRL_IRQ_FLAG_BIT = 7;
	localparam int CTRL_IRQ_EN_BIT   = 6;
	localparam int CTRL_PER_MSB_BIT  = 5;
	localparam int CTRL_UNLOCK_BIT   = 4;
	localparam int CTRL_RST_EN_BIT   = 3;
	localparam int CTRL_PER_LO_MSB   = 2;

	// Reset cause register fields
	localparam int CAUSE_DOG_BIT  = 3;
	localparam int CAUSE_LOW_BIT  = 2;
	localparam int CAUSE_PIN_BIT  = 1;
	localparam int CAUSE_PWR_BIT  = 0;
	localparam int CAUSE_USED_MSB = 3;

	// Reset values
	localparam logic [3:0] PERIOD_RST = 4'h0;
	localparam logic [3:0] CAUSE_RST  = 4'h1;

	// Timing
	localparam int unsigned UNLOCK_CYCLES   = 4;
	localparam int unsigned DEF_BASE_CYCLES = 2048;
	localparam logic [3:0]  PERIOD_MAX_CODE = 4'h9;
	localparam int          CNT_W           = 21;

	// Last count of a period; reserved codes act as the longest one
	function automatic logic [CNT_W-1:0] period_last(
		input logic [3:0] sel,
		input int unsigned base
	);
		logic [3:0] s;
		s = (sel > PERIOD_MAX_CODE) ? PERIOD_MAX_CODE : sel;
		return CNT_W'((base << s) - 1);
	endfunction

endpackage

// File: hdl/wdt_count_if.sv
// Link between the watchdog control logic and its period counter.
// Both ends run on sys_clk.
`timescale 1ns/1ps
`default_nettype none
interface wdt_count_if;
	logic       tick;
	logic       restart;
	logic       run;
	logic [3:0] period_sel;
	logic       timeout;

	modport ctrl (output tick, output restart, output run, output period_sel, input timeout);
	modport counter (input tick, input restart, input run, input period_sel, output timeout);
endinterface
`default_nettype wire

// File: hdl/wdt_period_counter.sv
// Counts oscillator ticks and pulses timeout at the selected period.
// Assumes tick is already synchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none
module wdt_period_counter import wdt_pkg::*; #(
	parameter int unsigned BASE_CYCLES = DEF_BASE_CYCLES
) (
	// Clock and reset
	input wire logic   sys_clk,
	input wire logic   srst,
	// Control side
	wdt_count_if.counter cnt
);
	logic [CNT_W-1:0] count_reg;
	logic             timeout_reg;
	logic [CNT_W-1:0] last_cnt;
	logic             at_end;

	assign last_cnt = period_last(cnt.period_sel, BASE_CYCLES);
	// A shortened period past the count fires on the next tick
	assign at_end = count_reg >= last_cnt;

	always_ff @(posedge sys_clk) begin
		if (srst || cnt.restart || !cnt.run) begin
			count_reg <= '0;
		end else if (cnt.tick) begin
			count_reg <= at_end ? '0 : count_reg + CNT_W'(1); // RULE7 RULE19
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			timeout_reg <= 1'b0;
		end else begin
			timeout_reg <= !cnt.restart && cnt.run && cnt.tick && at_end;
		end
	end

	assign cnt.timeout = timeout_reg;
endmodule
`default_nettype wire

// File: hdl/watchdog_with_reset_flags.sv
// Watchdog control with reset-cause flags, on an Avalon-MM slave.
// Assumes reset events and core strobes are sys_clk pulses;
// the watchdog oscillator arrives as a raw pin.
//
// Function
// RULE1: Unused cause bits 7:4 read zero
// RULE2: Dog flag set on watchdog reset
// RULE3: Low supply flag set on brown-out
// RULE4: Pin flag set on external reset
// RULE5: Power flag cleared only by software
// RULE6: Software reads then clears cause flags
// RULE7: Four-bit period code, 2048 doubling
// RULE8: Timeout in interrupt mode sets flag
// RULE9: Vector or write-one clears flag
// RULE10: Interrupt needs global, enable and flag
// RULE11: Enable bits select the four modes
// RULE12: Combined mode vector drops interrupt enable
// RULE13: Second combined timeout gives system reset
// RULE14: Protected fields need change unlock
// RULE15: Unlock clears itself after four cycles
// RULE16: Reset enable forced while dog flag
// RULE17: Software restarts count before period change
// RULE18: Unlock write then change within four
// RULE19: Count oscillator cycles, restart on request
// RULE20: Fuse forces system reset mode
// RULE21: Reset pulse lasts one clock
// RULE22: Oscillator and restart cross safely
//
// Design decision made here: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module watchdog_with_reset_flags import wdt_pkg::*; #(
	parameter int unsigned BASE_CYCLES = DEF_BASE_CYCLES
) (
	// Clock and reset
	input wire logic         sys_clk,
	input wire logic         srst,
	// Avalon-MM slave
	input wire logic [7:0]   avs_address,
	input wire logic         avs_read,
	input wire logic         avs_write,
	input wire logic [31:0]  avs_writedata,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	// Processor core
	input wire logic         processor_flags,
	input wire logic         restart_req,
	input wire logic         vector_taken,
	output logic             irq_request,
	// Reset controller and fuse
	input wire logic         low_supply_event,
	input wire logic         pin_reset_event,
	input wire logic         always_on_fuse,
	output logic             dog_reset_pulse,
	// Watchdog oscillator pin
	input wire logic         wdt_osc
);
	typedef enum logic {
		BUS_IDLE   = 1'b0,
		BUS_ANSWER = 1'b1
	} bus_state_t;

	wdt_count_if cnt_if ();

	bus_state_t  state_reg;
	logic        waitreq_reg;
	logic [31:0] readdata_reg;
	logic        osc_s1_reg;
	logic        osc_s2_reg;
	logic        osc_s3_reg;
	logic        osc_lvl_reg;
	logic        timeout_irq_flag;
	logic        timeout_irq_enable;
	logic        timeout_reset_enable;
	logic        change_unlock;
	logic [3:0]  period_select;
	logic [2:0]  unlock_cnt_reg;
	logic        dog_reset_cause_flag;
	logic        low_supply_cause_flag;
	logic        pin_reset_cause_flag;
	logic        power_up_cause_flag;
	logic        irq_reg;
	logic        dog_pulse_reg;

	logic        wr_commit;
	logic        ctrl_wr;
	logic        cause_wr;
	logic        re_eff;
	logic        ie_eff;
	logic        set_flag;
	logic        dog_fire;
	logic        sys_clear;
	logic        unlock_req;
	logic [7:0]  ctrl_view;
	logic [7:0]  cause_view;

	// Bus slave: one wait cycle, then a single answer cycle
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			state_reg   <= BUS_IDLE;
			waitreq_reg <= 1'b1;
		end else begin
			unique case (state_reg)
				BUS_IDLE: begin
					if (avs_read || avs_write) begin
						state_reg   <= BUS_ANSWER;
						waitreq_reg <= 1'b0;
					end
				end
				BUS_ANSWER: begin
					state_reg   <= BUS_IDLE;
					waitreq_reg <= 1'b1;
				end
			endcase
		end
	end

	assign wr_commit = (state_reg == BUS_ANSWER) && avs_write;
	assign ctrl_wr   = wr_commit && (avs_address == CTRL_OFS);
	assign cause_wr  = wr_commit && (avs_address == CAUSE_OFS);

	assign re_eff = timeout_reset_enable || always_on_fuse || dog_reset_cause_flag; // RULE20 RULE16
	assign ie_eff = timeout_irq_enable && !always_on_fuse;

	assign ctrl_view = {timeout_irq_flag, ie_eff, period_select[3], change_unlock,
		re_eff, period_select[2:0]};
	assign cause_view = {4'h0, dog_reset_cause_flag, low_supply_cause_flag, // RULE1
		pin_reset_cause_flag, power_up_cause_flag};

	// Unmapped offsets read zero
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			readdata_reg <= 32'h0000_0000;
		end else if (state_reg == BUS_IDLE && avs_read) begin
			if (avs_address == CTRL_OFS) begin
				readdata_reg <= {24'h00_0000, ctrl_view};
			end else if (avs_address == CAUSE_OFS) begin
				readdata_reg <= {24'h00_0000, cause_view};
			end else begin
				readdata_reg <= 32'h0000_0000;
			end
		end
	end

	// Not reset: the pin runs on through srst, so no false rise follows it
	always_ff @(posedge sys_clk) begin
		osc_s1_reg  <= wdt_osc; // RULE22
		osc_s2_reg  <= osc_s1_reg;
		osc_s3_reg  <= osc_s2_reg;
		osc_lvl_reg <= (osc_s2_reg == osc_s3_reg) ? osc_s3_reg : osc_lvl_reg;
	end

	assign cnt_if.tick       = osc_s2_reg && osc_s3_reg && !osc_lvl_reg; // RULE22 RULE19
	assign cnt_if.restart    = restart_req || sys_clear; // RULE19
	assign cnt_if.run        = re_eff || ie_eff; // RULE11
	assign cnt_if.period_sel = period_select;

	wdt_period_counter #(
		.BASE_CYCLES (BASE_CYCLES)
	) u_counter (
		.sys_clk (sys_clk),
		.srst    (srst),
		.cnt     (cnt_if.counter)
	);

	// Timeout action by mode
	always_comb begin
		set_flag = 1'b0;
		dog_fire = 1'b0;
		if (cnt_if.timeout) begin
			if (always_on_fuse) begin
				dog_fire = 1'b1; // RULE20
			end else if (ie_eff && !re_eff) begin
				set_flag = 1'b1; // RULE8 RULE11
			end else if (re_eff && !ie_eff) begin
				dog_fire = 1'b1; // RULE11
			end else if (re_eff && ie_eff) begin
				set_flag = !timeout_irq_flag; // RULE12
				dog_fire = timeout_irq_flag; // RULE13
			end
		end
	end

	// Any system reset returns the control fields to reset state
	assign sys_clear = dog_fire || low_supply_event || pin_reset_event;

	assign unlock_req = ctrl_wr && avs_writedata[CTRL_UNLOCK_BIT]
		&& avs_writedata[CTRL_RST_EN_BIT];

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			dog_pulse_reg <= 1'b0;
		end else begin
			dog_pulse_reg <= dog_fire; // RULE21
		end
	end

	// Change unlock and its four-cycle window
	always_ff @(posedge sys_clk) begin
		if (srst || sys_clear) begin
			change_unlock  <= 1'b0;
			unlock_cnt_reg <= 3'h0;
		end else if (unlock_req) begin
			change_unlock  <= 1'b1; // RULE18
			unlock_cnt_reg <= 3'h0;
		end else if (ctrl_wr && !avs_writedata[CTRL_UNLOCK_BIT]) begin
			change_unlock  <= 1'b0;
		end else if (change_unlock) begin
			unlock_cnt_reg <= unlock_cnt_reg + 3'h1;
			if (unlock_cnt_reg == 3'(UNLOCK_CYCLES - 1)) begin
				change_unlock <= 1'b0; // RULE15
			end
		end
	end

	// Reset enable: clearing needs unlock, dog flag forces it
	always_ff @(posedge sys_clk) begin
		if (srst || sys_clear) begin
			timeout_reset_enable <= 1'b0;
		end else if (dog_reset_cause_flag) begin
			timeout_reset_enable <= 1'b1; // RULE16
		end else if (ctrl_wr) begin
			if (avs_writedata[CTRL_RST_EN_BIT] || change_unlock) begin
				timeout_reset_enable <= avs_writedata[CTRL_RST_EN_BIT]; // RULE14
			end
		end
	end

	// Period select changes only while change unlock is set, for any write
	always_ff @(posedge sys_clk) begin
		if (srst || sys_clear) begin
			period_select <= PERIOD_RST;
		end else if (ctrl_wr && change_unlock) begin
			period_select <= {avs_writedata[CTRL_PER_MSB_BIT], // RULE14 RULE7
				avs_writedata[CTRL_PER_LO_MSB:0]};
		end
	end

	// Interrupt enable; the vector drops it in combined mode
	always_ff @(posedge sys_clk) begin
		if (srst || sys_clear || always_on_fuse) begin
			timeout_irq_enable <= 1'b0; // RULE20
		end else if (vector_taken && timeout_reset_enable) begin
			timeout_irq_enable <= 1'b0; // RULE12
		end else if (ctrl_wr) begin
			timeout_irq_enable <= avs_writedata[CTRL_IRQ_EN_BIT];
		end
	end

	// Set wins over vector or write-one clear
	always_ff @(posedge sys_clk) begin
		if (srst || sys_clear) begin
			timeout_irq_flag <= 1'b0;
		end else if (set_flag) begin
			timeout_irq_flag <= 1'b1; // RULE8
		end else if (vector_taken || (ctrl_wr && avs_writedata[CTRL_IRQ_FLAG_BIT])) begin
			timeout_irq_flag <= 1'b0; // RULE9
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= processor_flags && ie_eff && timeout_irq_flag // RULE10
				&& !vector_taken;
		end
	end

	// Cause flags: power-on is srst; a new cause wins over a clear
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			dog_reset_cause_flag  <= CAUSE_RST[CAUSE_DOG_BIT];
			low_supply_cause_flag <= CAUSE_RST[CAUSE_LOW_BIT];
			pin_reset_cause_flag  <= CAUSE_RST[CAUSE_PIN_BIT];
		end else begin
			if (dog_fire) begin
				dog_reset_cause_flag <= 1'b1; // RULE2
			end else if (cause_wr && !avs_writedata[CAUSE_DOG_BIT]) begin
				dog_reset_cause_flag <= 1'b0; // RULE2
			end
			if (low_supply_event) begin
				low_supply_cause_flag <= 1'b1; // RULE3
			end else if (cause_wr && !avs_writedata[CAUSE_LOW_BIT]) begin
				low_supply_cause_flag <= 1'b0; // RULE3
			end
			if (pin_reset_event) begin
				pin_reset_cause_flag <= 1'b1; // RULE4
			end else if (cause_wr && !avs_writedata[CAUSE_PIN_BIT]) begin
				pin_reset_cause_flag <= 1'b0; // RULE4
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			power_up_cause_flag <= CAUSE_RST[CAUSE_PWR_BIT]; // RULE5
		end else if (cause_wr && !avs_writedata[CAUSE_PWR_BIT]) begin
			power_up_cause_flag <= 1'b0; // RULE5
		end
	end

	assign avs_readdata    = readdata_reg;
	assign avs_waitrequest = waitreq_reg;
	assign irq_request     = irq_reg;
	assign dog_reset_pulse = dog_pulse_reg;

	// Checks
	localparam int ULK_WIN = UNLOCK_CYCLES;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (srst);

	sequence combined_armed_s;
		cnt_if.timeout && re_eff && ie_eff && !always_on_fuse;
	endsequence
	sequence flag_pending_s;
		combined_armed_s ##0 timeout_irq_flag;
	endsequence

	cause_rsv_zero_a: assert property ( // RULE1
		(state_reg == BUS_ANSWER && avs_read && avs_address == CAUSE_OFS)
			|-> readdata_reg[31:CAUSE_USED_MSB+1] == '0)
		else $error("cause reserved bits not zero");

	dog_flag_set_a: assert property ( // RULE2
		dog_pulse_reg |-> dog_reset_cause_flag && re_eff)
		else $error("dog pulse without dog flag");

	low_flag_set_a: assert property ( // RULE3
		low_supply_event |=> low_supply_cause_flag)
		else $error("low supply flag not set");

	pin_flag_set_a: assert property ( // RULE4
		pin_reset_event |=> pin_reset_cause_flag)
		else $error("pin reset flag not set");

	power_flag_hold_a: assert property ( // RULE5
		$fell(power_up_cause_flag) |-> $past(cause_wr))
		else $error("power flag lost without write");

	period_guard_a: assert property ( // RULE14
		$changed(period_select) && !$past(srst)
			|-> $past(change_unlock) || $past(sys_clear))
		else $error("period changed while locked");

	irq_flag_set_a: assert property ( // RULE8
		cnt_if.timeout && ie_eff && !re_eff |=> timeout_irq_flag)
		else $error("irq flag not set on timeout");

	second_timeout_a: assert property ( // RULE13
		flag_pending_s |=> dog_pulse_reg ##1 !dog_pulse_reg)
		else $error("no single reset pulse on second timeout");

	first_timeout_a: assert property ( // RULE12
		combined_armed_s ##0 !timeout_irq_flag |=> timeout_irq_flag && !dog_pulse_reg)
		else $error("first combined timeout wrong");

	unlock_expire_a: assert property ( // RULE15
		$rose(change_unlock) |-> ##[1:ULK_WIN] !change_unlock)
		else $error("unlock held too long");
	irq_gate_a: assert property ( // RULE10
		irq_request |-> $past(processor_flags) && $past(timeout_irq_flag))
		else $error("irq without global enable and flag");
	fuse_reset_a: assert property ( // RULE20
		cnt_if.timeout && always_on_fuse |=> dog_pulse_reg && !timeout_irq_flag)
		else $error("fuse did not force reset");
endmodule
`default_nettype wire

// File: verif/wdt_partner.sv
// Watchdog oscillator and reset controller model.
// Assumes a 100 MHz sys_clk; the oscillator is sped up for simulation.
`timescale 1ns/1ps
`default_nettype none
module wdt_partner #(
	parameter realtime OSC_HALF = 200.0
) (
	// Clock
	input wire logic sys_clk,
	// Watchdog side
	input wire logic dog_reset_pulse,
	output logic     wdt_osc,
	output var int   pulse_count,
	output var int   width_err
);
	logic prev;
	// Free running, phase unrelated to sys_clk
	initial begin
		wdt_osc = 1'b0;
		#3.3;
		forever #(OSC_HALF) wdt_osc = ~wdt_osc;
	end
	initial begin
		pulse_count = 0;
		width_err = 0;
		prev = 1'b0;
	end
	// Reset controller sees each pulse; a long one is a fault
	always @(posedge sys_clk) begin
		if (dog_reset_pulse === 1'b1)
			pulse_count <= pulse_count + 1;
		if (dog_reset_pulse === 1'b1 && prev === 1'b1)
			width_err <= width_err + 1;
		prev <= dog_reset_pulse;
	end
endmodule
`default_nettype wire

// File: verif/tb_watchdog_with_reset_flags.sv
// Self-checking bench of the watchdog with reset-cause flags.
// Assumes BASE_CYCLES of 4 and an oscillator period of 40 sys_clk cycles.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin bad_count++; \
	$display("wrong value at %0t: got %h want %h", $time, (a), (e)); end end
module tb_watchdog_with_reset_flags import wdt_pkg::*; ();
	logic        sys_clk;
	logic        srst;
	logic [7:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        pf;
	logic [3:0]  ev;
	logic        irq_request;
	logic        fuse;
	logic        dog_reset_pulse;
	logic        wdt_osc;
	int          p_cnt;
	int          w_err;
	int          bad_count;
	int          num_checks;

	watchdog_with_reset_flags #(.BASE_CYCLES(4)) dut (
		.sys_clk(sys_clk), .srst(srst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.processor_flags(pf), .restart_req(ev[2]), .vector_taken(ev[3]),
		.irq_request(irq_request), .low_supply_event(ev[0]),
		.pin_reset_event(ev[1]), .always_on_fuse(fuse),
		.dog_reset_pulse(dog_reset_pulse), .wdt_osc(wdt_osc));

	wdt_partner #(.OSC_HALF(200.0)) partner (
		.sys_clk(sys_clk), .dog_reset_pulse(dog_reset_pulse), .wdt_osc(wdt_osc),
		.pulse_count(p_cnt), .width_err(w_err));

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Request held until waitrequest is seen low at a rising edge
	task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] q);
		int n;
		n = 0;
		@(posedge sys_clk);
		avs_address <= a;
		avs_writedata <= {24'h00_0000, d};
		avs_write <= wr;
		avs_read <= ~wr;
		do begin
			@(posedge sys_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		q = avs_readdata[7:0];
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		`CHK(n < 20, 1'b1)
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] q;
		bus(1'b0, a, 8'h00, q);
		`CHK(q, e)
	endtask
	task automatic pulse(input int i);
		@(posedge sys_clk);
		ev[i] <= 1'b1;
		@(posedge sys_clk);
		ev[i] <= 1'b0;
	endtask
	task automatic do_reset(input int n);
		@(posedge sys_clk);
		srst <= 1'b1;
		repeat (n) @(posedge sys_clk);
		srst <= 1'b0;
	endtask
	task automatic wait_dog(input int lo, input int hi);
		int n;
		n = 0;
		while (dog_reset_pulse !== 1'b1 && n < hi + 50) begin
			@(negedge sys_clk);
			n++;
		end
		`CHK(n >= lo && n <= hi, 1'b1)
	endtask
	task automatic wait_irq();
		int n;
		n = 0;
		while (irq_request !== 1'b1 && n < 400) begin
			@(negedge sys_clk);
			n++;
		end
		`CHK(irq_request, 1'b1)
	endtask
	// Dog flag first, since it holds reset enable up
	task automatic stop_dog();
		wr(CAUSE_OFS, 8'h00);
		wr(CTRL_OFS, 8'h18);
		wr(CTRL_OFS, 8'h00);
		rd(CTRL_OFS, 8'h00);
	endtask

	initial begin
		#500_000;
		bad_count++;
		results();
	end

	initial begin
		srst = 1'b1;
		avs_address = 8'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0000_0000;
		pf = 1'b1;
		ev = 4'h0;
		fuse = 1'b0;
		bad_count = 0;
		num_checks = 0;
		repeat (10) @(posedge sys_clk);
		srst <= 1'b0;
		rd(CAUSE_OFS, 8'h01);
		wr(8'h70, 8'hFF);
		rd(8'h70, 8'h00);
		rd(CTRL_OFS, 8'h00);
		$display("test reset values done");
		pulse(0);
		pulse(1);
		rd(CAUSE_OFS, 8'h07);
		wr(CAUSE_OFS, 8'hFF);
		rd(CAUSE_OFS, 8'h07);
		wr(CAUSE_OFS, 8'h00);
		rd(CAUSE_OFS, 8'h00);
		pulse(0);
		rd(CAUSE_OFS, 8'h04);
		do_reset(2);
		rd(CAUSE_OFS, 8'h01);
		$display("test cause flags done");
		wr(CTRL_OFS, 8'h40);
		wait_irq();
		rd(CTRL_OFS, 8'hC0);
		pf <= 1'b0;
		repeat (2) @(posedge sys_clk);
		@(negedge sys_clk);
		`CHK(irq_request, 1'b0)
		@(posedge sys_clk);
		pf <= 1'b1;
		pulse(3);
		rd(CTRL_OFS, 8'h40);
		wait_irq();
		wr(CTRL_OFS, 8'hC0);
		rd(CTRL_OFS, 8'h40);
		`CHK(p_cnt, 0)
		wr(CTRL_OFS, 8'h00);
		repeat (300) @(posedge sys_clk);
		rd(CTRL_OFS, 8'h00);
		$display("test interrupt mode done");
		pulse(2);
		wr(CTRL_OFS, 8'h18);
		wr(CTRL_OFS, 8'h09);
		rd(CTRL_OFS, 8'h09);
		pulse(2);
		wait_dog(280, 400);
		rd(CAUSE_OFS, 8'h09);
		rd(CTRL_OFS, 8'h08);
		wr(CTRL_OFS, 8'h00);
		rd(CTRL_OFS, 8'h08);
		wr(CTRL_OFS, 8'h18);
		wr(CTRL_OFS, 8'h00);
		rd(CTRL_OFS, 8'h08);
		stop_dog();
		$display("test reset mode done");
		wr(CTRL_OFS, 8'h08);
		wr(CTRL_OFS, 8'h18);
		repeat (6) @(posedge sys_clk);
		rd(CTRL_OFS, 8'h08);
		wr(CTRL_OFS, 8'h00);
		rd(CTRL_OFS, 8'h08);
		for (int i = 0; i < 20; i++) begin
			pulse(2);
			repeat (48) @(posedge sys_clk);
		end
		`CHK(p_cnt, 1)
		wait_dog(40, 220);
		stop_dog();
		$display("test restart done");
		wr(CTRL_OFS, 8'h48);
		wait_irq();
		pulse(3);
		rd(CTRL_OFS, 8'h08);
		stop_dog();
		wr(CTRL_OFS, 8'h48);
		wait_dog(250, 420);
		rd(CAUSE_OFS, 8'h08);
		stop_dog();
		$display("test combined mode done");
		fuse <= 1'b1;
		do_reset(2);
		rd(CTRL_OFS, 8'h08);
		wr(CTRL_OFS, 8'h40);
		rd(CTRL_OFS, 8'h08);
		wait_dog(100, 240);
		`CHK(w_err, 0)
		$display("test fuse done");
		results();
	end
endmodule
`default_nettype wire
